// >>> core/rpc_pkg.sv
/*
 * Constants for the page and adjust control of the on-chip real-time clock:
 * register offsets, field positions, reset values and second counts.
 * Assumes an 8-bit register port with a 13-bit byte address.
 */
package rpc_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Register port geometry and offsets.
	localparam int unsigned RPC_AW = 13;
	localparam int unsigned RPC_DW = 8;

	localparam logic [12:0] RPC_SEC_ADDR    = 13'h0320;
	localparam logic [12:0] RPC_LEAP_ADDR   = 13'h0326;
	localparam logic [12:0] RPC_PAGE_ADDR   = 13'h0327;
	localparam logic [12:0] RPC_RSTSEL_ADDR = 13'h1328;
	localparam logic [12:0] RPC_STAT_ADDR   = 13'h032c;
	localparam logic [12:0] RPC_MASK_ADDR   = 13'h032d;

	////////////////////////////////////////////////////////////////////////////////
	// Field positions of the page and enable register.
	localparam int unsigned RPC_PG_PAGE   = 0;
	localparam int unsigned RPC_PG_ALM_EN = 2;
	localparam int unsigned RPC_PG_TK_EN  = 3;
	localparam int unsigned RPC_PG_ADJ    = 4;
	localparam int unsigned RPC_PG_IRQ_EN = 7;

	// Field positions of the reset and output select register.
	localparam int unsigned RPC_RS_ALM_CLR = 4;
	localparam int unsigned RPC_RS_CNT_CLR = 5;
	localparam int unsigned RPC_RS_SIX_OFF = 6;
	localparam int unsigned RPC_RS_ONE_OFF = 7;

	// Status and mask bit positions.
	localparam int unsigned RPC_ST_CLK = 0;
	localparam int unsigned RPC_ST_SEC = 1;
	localparam int unsigned RPC_ST_MIN = 2;
	localparam int unsigned RPC_NST    = 3;

	////////////////////////////////////////////////////////////////////////////////
	// Values after reset.
	localparam logic       RPC_BIT_RST     = 1'b0;
	localparam logic [1:0] RPC_LEAP_RST    = 2'h0;
	localparam logic       RPC_OUT_OFF_RST = 1'b1;
	localparam logic [2:0] RPC_MASK_RST    = 3'h0;
	localparam logic [2:0] RPC_STAT_RST    = 3'h0;
	localparam logic [5:0] RPC_SEC_RST     = 6'h00;
	localparam logic [7:0] RPC_RD_RST      = 8'h00;

	// Second counts: last value of a minute and first value that rounds up.
	localparam logic [5:0] RPC_SEC_MAX  = 6'h3b;
	localparam logic [5:0] RPC_SEC_HALF = 6'h1e;

endpackage : rpc_pkg

// >>> core/rpc_sec_if.sv
/*
 * Bundle between the control block and the seconds counter.
 * Assumes both ends run on ref_clk.
 */
`timescale 1ns/1ps

interface rpc_sec_if;
	logic       tick;
	logic       enable;
	logic       adjust;
	logic       clear;
	logic       wr_en;
	logic [5:0] wr_data;
	logic [5:0] sec;
	logic       advanced;
	logic       min_carry;

	modport ctrl (
		output tick,
		output enable,
		output adjust,
		output clear,
		output wr_en,
		output wr_data,
		input  sec,
		input  advanced,
		input  min_carry
	);

	modport cnt (
		input  tick,
		input  enable,
		input  adjust,
		input  clear,
		input  wr_en,
		input  wr_data,
		output sec,
		output advanced,
		output min_carry
	);
endinterface : rpc_sec_if

// >>> core/rpc_sec_counter.sv
/*
 * Seconds counter with carry hold, rounding adjust and clear.
 * Assumes tick is a one-cycle pulse on ref_clk from the one-second divider.
 */
`timescale 1ns/1ps

module rpc_sec_counter
	import rpc_pkg::*;
(
	input  wire logic ref_clk,
	input  wire logic reset_n,
	rpc_sec_if.cnt    sif
);

	logic [5:0] sec_q, sec_d;
	logic       pend_q, pend_d;
	logic       adv_q, adv_d;
	logic       mc_q, mc_d;
	logic       step;

	always_comb begin
		sec_d  = sec_q;
		pend_d = pend_q;
		adv_d  = 1'b0;
		mc_d   = 1'b0;
		step   = 1'b0;
		if (sif.clear) begin
			sec_d  = RPC_SEC_RST;
			pend_d = 1'b0;
		end else begin
			// Only one carry is held; further ones while stopped are dropped.
			if (sif.tick && !sif.enable) begin
				pend_d = 1'b1;
			end
			step = sif.enable && (sif.tick || pend_q);
			if (sif.enable) begin
				pend_d = 1'b0;
			end
			if (step) begin
				// A carry in the same cycle as a write discards the write.
				adv_d = 1'b1;
				if (sec_q == RPC_SEC_MAX) begin
					sec_d = RPC_SEC_RST;
					mc_d  = 1'b1;
				end else begin
					sec_d = sec_q + 6'h01;
				end
			end else if (sif.wr_en) begin
				sec_d = sif.wr_data;
			end else if (sif.adjust) begin
				sec_d = RPC_SEC_RST;
				mc_d  = (sec_q >= RPC_SEC_HALF);
			end
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			sec_q  <= RPC_SEC_RST;
			pend_q <= 1'b0;
			adv_q  <= 1'b0;
			mc_q   <= 1'b0;
		end else begin
			sec_q  <= sec_d;
			pend_q <= pend_d;
			adv_q  <= adv_d;
			mc_q   <= mc_d;
		end
	end

	assign sif.sec       = sec_q;
	assign sif.advanced  = adv_q;
	assign sif.min_carry = mc_q;

endmodule : rpc_sec_counter

// >>> core/rpc_clk_irq_src.sv
/*
 * Source select for the alarm pin and falling-edge clock interrupt pulse.
 * Assumes the 1 Hz and 16 Hz waves come from the 32 kHz domain and
 * alarm_match comes from logic on ref_clk.
 */
`timescale 1ns/1ps

module rpc_clk_irq_src
	import rpc_pkg::*;
(
	input  wire logic ref_clk,
	input  wire logic reset_n,
	input  wire logic one_hz_wave,
	input  wire logic sixteen_hz_wave,
	input  wire logic alarm_match,
	input  wire logic alarm_enable,
	input  wire logic one_hz_out_off,
	input  wire logic sixteen_hz_out_off,
	input  wire logic irq_enable,
	output logic      alarm_n,
	output logic      clock_irq,
	output logic      fall_seen
);

	logic [1:0] s1_q, s2_q;
	logic       src_q, src_d;
	logic       irq_q, irq_d;
	logic       fall_q, fall_d;

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			s1_q <= 2'h3;
			s2_q <= 2'h3;
		end else begin
			s1_q <= {sixteen_hz_wave, one_hz_wave};
			s2_q <= s1_q;
		end
	end

	always_comb begin
		unique case ({one_hz_out_off, sixteen_hz_out_off, alarm_enable})
			3'b111:  src_d = ~alarm_match;
			3'b010:  src_d = s2_q[0];
			3'b100:  src_d = s2_q[1];
			default: src_d = 1'b1;
		endcase
		fall_d = src_q && !src_d;
		irq_d  = fall_d && irq_enable;
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			src_q  <= 1'b1;
			irq_q  <= 1'b0;
			fall_q <= 1'b0;
		end else begin
			src_q  <= src_d;
			irq_q  <= irq_d;
			fall_q <= fall_d;
		end
	end

	assign alarm_n   = src_q;
	assign clock_irq = irq_q;
	assign fall_seen = fall_q;

endmodule : rpc_clk_irq_src

// >>> core/rpc_page_ctrl.sv
/*
 * Page and enable control of the real-time clock: register port, page
 * view, leap phase, seconds adjust, counter and alarm clear, output
 * select and interrupt status.
 * Assumes a register master on ref_clk, a one-second carry pulse on
 * ref_clk and the alarm comparator outside.
 */
// Implementation choice: the strobed register port.
`timescale 1ns/1ps

module rpc_page_ctrl
	import rpc_pkg::*;
(
	input  wire logic        ref_clk,
	input  wire logic        reset_n,
	input  wire logic [12:0] addr,
	input  wire logic [7:0]  wr_data,
	input  wire logic        wr_stb,
	input  wire logic        rd_stb,
	output logic      [7:0]  rd_data,
	input  wire logic        one_sec_carry,
	input  wire logic        one_hz_wave,
	input  wire logic        sixteen_hz_wave,
	input  wire logic        alarm_match,
	output logic             alarm_n,
	output logic             clock_irq,
	output logic             irq,
	output logic             page_sel,
	output logic      [1:0]  leap_phase_val,
	output logic             counter_clear,
	output logic             alarm_clear,
	output logic             minute_carry,
	output logic      [5:0]  seconds
);

	////////////////////////////////////////////////////////////////////////////////
	// Address decode.
	logic page_q, page_d;
	logic wr_sec, wr_leap, wr_page, wr_rstsel, wr_stat, wr_mask;

	always_comb begin
		wr_sec    = wr_stb && (addr == RPC_SEC_ADDR) && !page_q;
		wr_leap   = wr_stb && (addr == RPC_LEAP_ADDR) && page_q;
		wr_page   = wr_stb && (addr == RPC_PAGE_ADDR);
		wr_rstsel = wr_stb && (addr == RPC_RSTSEL_ADDR);
		wr_stat   = wr_stb && (addr == RPC_STAT_ADDR);
		wr_mask   = wr_stb && (addr == RPC_MASK_ADDR);
	end

	////////////////////////////////////////////////////////////////////////////////
	// Page and enable register.
	logic alm_en_q, alm_en_d;
	logic tk_en_q, tk_en_d;
	logic adj_q, adj_d;
	logic irq_en_q, irq_en_d;

	always_comb begin
		page_d   = page_q;
		alm_en_d = alm_en_q;
		tk_en_d  = tk_en_q;
		irq_en_d = irq_en_q;
		adj_d    = 1'b0;
		if (wr_page) begin
			page_d   = wr_data[RPC_PG_PAGE];
			alm_en_d = wr_data[RPC_PG_ALM_EN];
			tk_en_d  = wr_data[RPC_PG_TK_EN];
			irq_en_d = wr_data[RPC_PG_IRQ_EN];
			// Rounding only acts when the timekeeping page is in view.
			adj_d    = wr_data[RPC_PG_ADJ] && !page_q;
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			page_q   <= RPC_BIT_RST;
			alm_en_q <= RPC_BIT_RST;
			tk_en_q  <= RPC_BIT_RST;
			adj_q    <= RPC_BIT_RST;
			irq_en_q <= RPC_BIT_RST;
		end else begin
			page_q   <= page_d;
			alm_en_q <= alm_en_d;
			tk_en_q  <= tk_en_d;
			adj_q    <= adj_d;
			irq_en_q <= irq_en_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Leap phase register.
	logic [1:0] leap_q, leap_d;

	always_comb begin
		leap_d = leap_q;
		if (wr_leap) begin
			leap_d = wr_data[1:0];
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			leap_q <= RPC_LEAP_RST;
		end else begin
			leap_q <= leap_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Write-only reset and output select register.
	logic one_off_q, one_off_d;
	logic six_off_q, six_off_d;
	logic cnt_clr_q, cnt_clr_d;
	logic alm_clr_q, alm_clr_d;

	always_comb begin
		one_off_d = one_off_q;
		six_off_d = six_off_q;
		cnt_clr_d = 1'b0;
		alm_clr_d = 1'b0;
		if (wr_rstsel) begin
			one_off_d = wr_data[RPC_RS_ONE_OFF];
			six_off_d = wr_data[RPC_RS_SIX_OFF];
			cnt_clr_d = wr_data[RPC_RS_CNT_CLR];
			alm_clr_d = wr_data[RPC_RS_ALM_CLR];
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			one_off_q <= RPC_OUT_OFF_RST;
			six_off_q <= RPC_OUT_OFF_RST;
			cnt_clr_q <= RPC_BIT_RST;
			alm_clr_q <= RPC_BIT_RST;
		end else begin
			one_off_q <= one_off_d;
			six_off_q <= six_off_d;
			cnt_clr_q <= cnt_clr_d;
			alm_clr_q <= alm_clr_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Seconds counter and interrupt source.
	rpc_sec_if sif ();

	assign sif.tick    = one_sec_carry;
	assign sif.enable  = tk_en_q;
	assign sif.adjust  = adj_q;
	assign sif.clear   = cnt_clr_q;
	assign sif.wr_en   = wr_sec;
	assign sif.wr_data = wr_data[5:0];

	rpc_sec_counter u_sec (
		.ref_clk (ref_clk),
		.reset_n (reset_n),
		.sif     (sif)
	);

	logic fall_seen;

	rpc_clk_irq_src u_src (
		.ref_clk            (ref_clk),
		.reset_n            (reset_n),
		.one_hz_wave        (one_hz_wave),
		.sixteen_hz_wave    (sixteen_hz_wave),
		.alarm_match        (alarm_match),
		.alarm_enable       (alm_en_q),
		.one_hz_out_off     (one_off_q),
		.sixteen_hz_out_off (six_off_q),
		.irq_enable         (irq_en_q),
		.alarm_n            (alarm_n),
		.clock_irq          (clock_irq),
		.fall_seen          (fall_seen)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Sticky status, mask and interrupt line. A new event beats a clear.
	logic [2:0] stat_q, stat_d;
	logic [2:0] mask_q, mask_d;
	logic [2:0] events;
	logic       irq_q, irq_d;

	always_comb begin
		events              = '0;
		events[RPC_ST_CLK]  = fall_seen;
		events[RPC_ST_SEC]  = sif.advanced;
		events[RPC_ST_MIN]  = sif.min_carry;
		stat_d = stat_q;
		if (wr_stat) begin
			stat_d = stat_q & ~wr_data[2:0];
		end
		stat_d = stat_d | events;
		mask_d = mask_q;
		if (wr_mask) begin
			mask_d = wr_data[2:0];
		end
		irq_d = |(stat_d & mask_d);
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			stat_q <= RPC_STAT_RST;
			mask_q <= RPC_MASK_RST;
			irq_q  <= 1'b0;
		end else begin
			stat_q <= stat_d;
			mask_q <= mask_d;
			irq_q  <= irq_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Read path: data stand for the one cycle after the strobe.
	logic [7:0] rd_q, rd_d;

	always_comb begin
		rd_d = RPC_RD_RST;
		if (rd_stb) begin
			unique case (addr)
				RPC_SEC_ADDR: begin
					if (!page_q) begin
						rd_d = {2'h0, sif.sec};
					end
				end
				RPC_LEAP_ADDR: begin
					if (page_q) begin
						rd_d = {6'h00, leap_q};
					end
				end
				RPC_PAGE_ADDR: begin
					rd_d[RPC_PG_IRQ_EN] = irq_en_q;
					rd_d[RPC_PG_ADJ]    = adj_q;
					rd_d[RPC_PG_TK_EN]  = tk_en_q;
					rd_d[RPC_PG_ALM_EN] = alm_en_q;
					rd_d[RPC_PG_PAGE]   = page_q;
				end
				RPC_STAT_ADDR: rd_d = {5'h00, stat_q};
				RPC_MASK_ADDR: rd_d = {5'h00, mask_q};
				default:       rd_d = RPC_RD_RST;
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			rd_q <= RPC_RD_RST;
		end else begin
			rd_q <= rd_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs.
	assign rd_data        = rd_q;
	assign irq            = irq_q;
	assign page_sel       = page_q;
	assign leap_phase_val = leap_q;
	assign counter_clear  = cnt_clr_q;
	assign alarm_clear    = alm_clr_q;
	assign minute_carry   = sif.min_carry;
	assign seconds        = sif.sec;

endmodule : rpc_page_ctrl

// >>> bench/rpc_page_ctrl_props.sv
/* Checker for the page control block, bound to its top ports.
 * Assumes rpc_pkg is compiled first and one clock domain. */
`timescale 1ns/1ps
module rpc_page_ctrl_props
	import rpc_pkg::*;
(
	input wire logic        ref_clk,
	input wire logic        reset_n,
	input wire logic [12:0] addr,
	input wire logic [7:0]  wr_data,
	input wire logic        wr_stb,
	input wire logic        rd_stb,
	input wire logic [7:0]  rd_data,
	input wire logic        one_sec_carry,
	input wire logic        one_hz_wave,
	input wire logic        sixteen_hz_wave,
	input wire logic        alarm_match,
	input wire logic        alarm_n,
	input wire logic        clock_irq,
	input wire logic        irq,
	input wire logic        page_sel,
	input wire logic [1:0]  leap_phase_val,
	input wire logic        counter_clear,
	input wire logic        alarm_clear,
	input wire logic        minute_carry,
	input wire logic [5:0]  seconds
);
	default clocking dc @(posedge ref_clk);
	endclocking
	default disable iff (!reset_n);
	////////////////////////////////////////////////////////////////////////////////
	property p_rst_rd;
		$past(rd_stb) && $past(addr) == RPC_RSTSEL_ADDR |-> rd_data == 8'h00;
	endproperty
	a_rst_rd: assert property (p_rst_rd) else $error("reset register read not zero");
	property p_clr_val;
		wr_stb && addr == RPC_RSTSEL_ADDR
			|=> counter_clear == $past(wr_data[5]) && alarm_clear == $past(wr_data[4]);
	endproperty
	a_clr_val: assert property (p_clr_val) else $error("clear pulse wrong");
	property p_clr_src;
		counter_clear || alarm_clear |-> $past(wr_stb) && $past(addr) == RPC_RSTSEL_ADDR;
	endproperty
	a_clr_src: assert property (p_clr_src) else $error("clear pulse without write");
	property p_clr_sec;
		counter_clear |=> seconds == 6'h00;
	endproperty
	a_clr_sec: assert property (p_clr_sec) else $error("seconds not cleared");
	property p_leap_rd;
		$past(rd_stb) && $past(addr) == RPC_LEAP_ADDR
			|-> rd_data == ($past(page_sel) ? {6'h00, $past(leap_phase_val)} : 8'h00);
	endproperty
	a_leap_rd: assert property (p_leap_rd) else $error("leap read wrong");
	property p_page_rd;
		$past(rd_stb) && $past(addr) == RPC_PAGE_ADDR
			|-> rd_data[6:5] == 2'h0 && !rd_data[1] && rd_data[0] == $past(page_sel);
	endproperty
	a_page_rd: assert property (p_page_rd) else $error("page register read wrong");
	property p_page_wr;
		wr_stb && addr == RPC_PAGE_ADDR |=> page_sel == $past(wr_data[0]);
	endproperty
	a_page_wr: assert property (p_page_wr) else $error("page bit not taken");
	property p_adj_self;
		$past(rd_stb) && $past(addr) == RPC_PAGE_ADDR && !$past(wr_stb, 2) |-> !rd_data[4];
	endproperty
	a_adj_self: assert property (p_adj_self) else $error("adjust bit stuck");
	property p_adjust;
		!$past(one_sec_carry) && wr_stb && addr == RPC_PAGE_ADDR && wr_data[4] && !page_sel
			&& !one_sec_carry ##1 !one_sec_carry && !wr_stb
			|=> seconds == 6'h00 && minute_carry == ($past(seconds) >= RPC_SEC_HALF);
	endproperty
	a_adjust: assert property (p_adjust) else $error("adjust result wrong");
	property p_wrap;
		seconds == 6'h00 && $past(seconds) == RPC_SEC_MAX && !$past(counter_clear)
			&& !$past(wr_stb) |-> minute_carry;
	endproperty
	a_wrap: assert property (p_wrap) else $error("wrap without minute carry");
	property p_irq_pulse;
		clock_irq |=> !clock_irq;
	endproperty
	a_irq_pulse: assert property (p_irq_pulse) else $error("clock irq too long");
	c_min: cover property (minute_carry);
	c_clk_irq: cover property (clock_irq);
	c_irq: cover property ($rose(irq));
endmodule : rpc_page_ctrl_props

bind rpc_page_ctrl rpc_page_ctrl_props u_props (.ref_clk, .reset_n, .addr, .wr_data, .wr_stb,
	.rd_stb, .rd_data, .one_sec_carry, .one_hz_wave, .sixteen_hz_wave, .alarm_match, .alarm_n,
	.clock_irq, .irq, .page_sel, .leap_phase_val, .counter_clear, .alarm_clear, .minute_carry,
	.seconds);

// >>> bench/rpc_page_ctrl_tb_top.sv
/* Self-checking bench for the page control block.
 * Assumes rpc_pkg, the design and its checker are compiled first. */
`timescale 1ns/1ps
module rpc_page_ctrl_tb_top
	import rpc_pkg::*;
;
	logic        ref_clk, reset_n, wr_stb, rd_stb, one_sec_carry;
	logic [12:0] addr;
	logic [7:0]  wr_data, rd_data;
	logic        one_hz_wave, sixteen_hz_wave, alarm_match, alarm_n, clock_irq, irq;
	logic        page_sel, counter_clear, alarm_clear, minute_carry;
	logic [1:0]  leap_phase_val;
	logic [5:0]  seconds, s;
	int          fail_count = 0, check_count = 0, irq_pulses = 0;

	rpc_page_ctrl dut (.ref_clk, .reset_n, .addr, .wr_data, .wr_stb, .rd_stb, .rd_data,
		.one_sec_carry, .one_hz_wave, .sixteen_hz_wave, .alarm_match, .alarm_n, .clock_irq,
		.irq, .page_sel, .leap_phase_val, .counter_clear, .alarm_clear, .minute_carry,
		.seconds);

	initial begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) if (clock_irq === 1'b1) irq_pulses++;
	////////////////////////////////////////////////////////////////////////////////
	function automatic logic f_min(input logic [5:0] v);
		return v >= 6'h1e;
	endfunction : f_min
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task automatic wr(input logic [12:0] a, input logic [7:0] d, input logic c = 1'b0);
		@(posedge ref_clk);
		addr          <= a;
		wr_data       <= d;
		wr_stb        <= 1'b1;
		one_sec_carry <= c;
		@(posedge ref_clk);
		wr_stb        <= 1'b0;
		one_sec_carry <= 1'b0;
	endtask : wr
	task automatic rc(input logic [12:0] a, input logic [7:0] exp);
		@(posedge ref_clk);
		addr   <= a;
		rd_stb <= 1'b1;
		@(posedge ref_clk);
		rd_stb <= 1'b0;
		#1 chk(rd_data, exp);
	endtask : rc
	task automatic tick;
		@(posedge ref_clk);
		one_sec_carry <= 1'b1;
		@(posedge ref_clk);
		one_sec_carry <= 1'b0;
	endtask : tick
	task automatic wave(input int m, input logic lvl);
		@(posedge ref_clk);
		if (m == 0) one_hz_wave <= lvl;
		else sixteen_hz_wave <= lvl;
		repeat (8) @(posedge ref_clk);
		#1 chk({7'h0, alarm_n}, {7'h0, lvl});
	endtask : wave
	task automatic test_done;
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : test_done

	initial begin
		repeat (20000) @(posedge ref_clk);
		fail_count++;
		test_done();
	end
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		{addr, wr_data, wr_stb, rd_stb, one_sec_carry} = '0;
		{one_hz_wave, sixteen_hz_wave, alarm_match} = '0;
		reset_n = 1'b0;
		void'($urandom(32'hf765));
		repeat (2) @(posedge ref_clk);
		reset_n <= 1'b1;
		rc(RPC_PAGE_ADDR, 8'h00);
		rc(RPC_RSTSEL_ADDR, 8'h00);
		rc(13'h1fff, 8'h00);
		chk({6'h0, irq, alarm_n}, 8'h01);
		$display("test reset done");
		rc(RPC_LEAP_ADDR, 8'h00);
		wr(RPC_PAGE_ADDR, 8'h01);
		#1 chk({7'h0, page_sel}, 8'h01);
		for (int i = 0; i < 4; i++) begin
			wr(RPC_LEAP_ADDR, 8'(i));
			#1 chk({6'h0, leap_phase_val}, 8'(i));
			rc(RPC_LEAP_ADDR, 8'(i));
		end
		wr(RPC_SEC_ADDR, 8'h05);
		wr(RPC_PAGE_ADDR, 8'h08);
		rc(RPC_SEC_ADDR, 8'h00);
		rc(RPC_LEAP_ADDR, 8'h00);
		$display("test page done");
		for (int k = 0; k < 6; k++) begin
			s = (k == 2) ? 6'h1e : (k == 3) ? 6'h3b : 6'(k * 29);
			if (k > 3) s = 6'($urandom_range(59));
			wr(RPC_SEC_ADDR, {2'h0, s});
			rc(RPC_SEC_ADDR, {2'h0, s});
			wr(RPC_PAGE_ADDR, 8'h18);
			@(posedge ref_clk);
			#1 chk({1'b0, minute_carry, seconds}, {1'b0, f_min(s), 6'h00});
			rc(RPC_PAGE_ADDR, 8'h08);
		end
		wr(RPC_MASK_ADDR, 8'h02);
		wr(RPC_STAT_ADDR, 8'h07);
		tick();
		#1 chk({2'h0, seconds}, 8'h01);
		repeat (2) @(posedge ref_clk);
		#1 chk({7'h0, irq}, 8'h01);
		rc(RPC_STAT_ADDR, 8'h02);
		wr(RPC_SEC_ADDR, 8'h3b);
		tick();
		#1 chk({1'b0, minute_carry, seconds}, 8'h40);
		$display("test seconds done");
		wr(RPC_SEC_ADDR, 8'h0a);
		wr(RPC_PAGE_ADDR, 8'h00);
		tick();
		tick();
		rc(RPC_SEC_ADDR, 8'h0a);
		wr(RPC_PAGE_ADDR, 8'h08);
		@(posedge ref_clk);
		rc(RPC_SEC_ADDR, 8'h0b);
		wr(RPC_SEC_ADDR, 8'h20, 1'b1);
		rc(RPC_SEC_ADDR, 8'h0c);
		rc(RPC_SEC_ADDR, 8'h0c);
		$display("test hold done");
		wr(RPC_MASK_ADDR, 8'h01);
		wr(RPC_STAT_ADDR, 8'h07);
		wr(RPC_RSTSEL_ADDR, 8'h40);
		wave(0, 1'b1);
		wave(0, 1'b0);
		chk(8'(irq_pulses), 8'h00);
		chk({7'h0, irq}, 8'h01);
		wr(RPC_STAT_ADDR, 8'h01);
		#1 chk({7'h0, irq}, 8'h00);
		wr(RPC_PAGE_ADDR, 8'h88);
		for (int m = 0; m < 2; m++) begin
			wr(RPC_RSTSEL_ADDR, m == 0 ? 8'h40 : 8'h80);
			wave(m, 1'b1);
			wave(m, 1'b0);
			chk(8'(irq_pulses), 8'(m + 1));
		end
		wr(RPC_PAGE_ADDR, 8'h0c);
		wr(RPC_PAGE_ADDR, 8'h8c);
		wr(RPC_RSTSEL_ADDR, 8'hd0);
		#1 chk({6'h0, counter_clear, alarm_clear}, 8'h01);
		@(posedge ref_clk);
		alarm_match <= 1'b1;
		repeat (6) @(posedge ref_clk);
		#1 chk({7'h0, alarm_n}, 8'h00);
		chk(8'(irq_pulses), 8'h03);
		$display("test source done");
		wr(RPC_SEC_ADDR, 8'h14);
		wr(RPC_RSTSEL_ADDR, 8'hc0);
		#1 chk({6'h0, counter_clear, alarm_clear}, 8'h00);
		wr(RPC_RSTSEL_ADDR, 8'he0);
		#1 chk({6'h0, counter_clear, alarm_clear}, 8'h02);
		rc(RPC_SEC_ADDR, 8'h00);
		$display("test clear done");
		test_done();
	end
endmodule : rpc_page_ctrl_tb_top
